//--- verilog/hxd_pkg.sv
// Purpose: shared constants and carriers for the hex half-bridge driver control block
// Assumes: 16-bit frames, least significant bit first
// Notes:   field positions follow the frame layout on both directions
package hxd_pkg;
  localparam int FRAME_BITS     = 16;
  localparam int CH_COUNT       = 6;
  localparam int OUT_COUNT      = 12;
  localparam int BIT_SRR        = 0;
  localparam int BIT_OUT_LO     = 1;
  localparam int BIT_OCD        = 13;
  localparam int BIT_ULD        = 14;
  localparam int BIT_OVERVOLTAGE_SHUTDOWN_ENABLE       = 15;
  localparam int BIT_TW         = 0;
  localparam int BIT_OLD_ST     = 13;
  localparam int BIT_ULD_ST     = 14;
  localparam int BIT_PSF        = 15;
  localparam logic [15:0] FRAME_RST = 16'h0000;
  localparam logic [3:0]  CNT_RST   = 4'h0;
  // underload delay, in microseconds, counted at 100 MHz
  localparam int ULD_DELAY_US   = 200;
  localparam int CLK_MHZ        = 100;
  localparam int ULD_DELAY_CYC  = ULD_DELAY_US * CLK_MHZ;

  typedef struct packed {
    logic       overvoltage_shutdown_enable_en;
    logic       uld_en;
    logic       ocd_en;
    logic [11:0] outs;
    logic       status_reset_command;
  } hxd_cmd_t;

  typedef struct packed {
    logic [CH_COUNT-1:0] tw;
    logic [CH_COUNT-1:0] ot;
    logic [OUT_COUNT-1:0] oc;
    logic [OUT_COUNT-1:0] ul;
    logic                 ov;
    logic                 uv_drv;
    logic                 vcc_ok;
  } hxd_sense_t;
endpackage

//--- verilog/hxd_sync.sv
// Purpose: two flip-flop level synchroniser, vector wide
// Assumes: inputs are quasi-static levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module hxd_sync #(
  parameter int W        = 1,
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= {W{RST_VAL}};
      q_o     <= {W{RST_VAL}};
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule // hxd_sync

//--- verilog/hxd_core.sv
// Purpose: serial command link and fault protection for a six-channel half-bridge driver
// Assumes: serial link mode 0 style, data sampled on rising sclk, shifted out on falling sclk
// Notes:   sense inputs are asynchronous levels from analog comparators
// How it works
// R01: sixteen-bit frame, lsb first, applied on chip select rise, serial_out off when high
// R02: input bit 0 status reset, bits 1-12 outputs, 13-15 shutdown enables
// R03: output bits 15 supply fail, 14 underload, 13 overload, 12-1 outputs, 0 warning
// R04: sleep clears every command and status state
// R05: floating chip select reads as deasserted, no transfer taken
// R06: all drivers start off and stay off until commanded on
// R07: logic supply power-up resets logic; frames taken only after lockout released
// R08: output stays on until driver undervoltage, command off, or fault
// R09: overcurrent with shutdown disabled leaves outputs on, current limited only
// R10: overcurrent with shutdown enabled latches that output off until status reset
// R11: any overcurrent sets sticky overload flag until status reset
// R12: outputs refused while any sensor is over temperature
// R13: underload longer than delay sets sticky underload flag
// R14: underload latches offending output off only when shutdown enabled
// R15: overvoltage sets sticky supply fail; turns all off when enabled
// R16: overvoltage keeps selection, outputs restored when supply returns
// R17: thermal warning sets sticky flag, outputs stay on
// R18: any over temperature turns all channels off, selection kept
// R19: status reset command clears warning and all sticky fault flags
// R20: chip select fall drives warning bit on serial_out at once
// R21: host reads serial_out low as no warning, high as warning
// R22: latched-off outputs released by status reset at end of that frame
`timescale 1ns/10ps
module hxd_core #(
  parameter int ULD_CYC = hxd_pkg::ULD_DELAY_CYC
) (
  // system clock and power-up reset
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  // device enable, low is sleep
  input  wire logic               enable_i,
  // serial link
  input  wire logic               sclk_i,
  input  wire logic               chip_select_n_i,
  input  wire logic               chip_select_n_oe_i,
  input  wire logic               serial_in_i,
  output logic                    serial_out_o,
  output logic                    serial_out_oe_o,
  // analog sense levels
  input  wire hxd_pkg::hxd_sense_t sense_i,
  // half-bridge gate drive
  output logic [11:0]             half_bridge_output_o
);
  localparam int UW = $clog2(ULD_CYC + 1);

  // R05: undriven chip select is high
  logic csn;
  assign csn = chip_select_n_i | ~chip_select_n_oe_i;

  // link domain reset: power-up or sleep
  logic link_rst;
  assign link_rst = sys_rst_i | ~enable_i;

  // ---------------- link domain (sclk) ----------------
  logic [15:0] shift_ff;
  logic [15:0] rx_ff;
  logic [3:0]  cnt_ff;
  logic        full_ff;
  logic        frame_tgl_ff;
  logic [15:0] status_word;
  logic [15:0] stat_hold_ff;

  // count restarts while chip select is high, so a cut frame leaves nothing behind
  logic cnt_rst;
  assign cnt_rst = link_rst | csn;

  // R01: lsb first shift on rising sclk
  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      shift_ff <= hxd_pkg::FRAME_RST;
    end else if (!csn) begin
      shift_ff <= {serial_in_i, shift_ff[15:1]};
    end
  end

  // R01: edge count; full marks a whole word seen, so a select-only poll applies nothing
  // limitation: capture on chip select rise must read these before their reset lands
  always_ff @(posedge sclk_i or posedge cnt_rst) begin
    if (cnt_rst) begin
      cnt_ff  <= hxd_pkg::CNT_RST;
      full_ff <= 1'b0;
    end else begin
      cnt_ff  <= cnt_ff + 4'h1;
      full_ff <= full_ff | (&cnt_ff);
    end
  end

  // serial out: falling sclk advances next status bit
  logic [3:0] tx_idx_ff;
  always_ff @(negedge sclk_i or posedge csn) begin
    if (csn) begin
      tx_idx_ff <= hxd_pkg::CNT_RST;
    end else begin
      tx_idx_ff <= tx_idx_ff + 4'h1;
    end
  end

  // R01: capture frame on chip select rise, full frames only
  always_ff @(posedge csn or posedge link_rst) begin
    if (link_rst) begin
      rx_ff        <= hxd_pkg::FRAME_RST;
      frame_tgl_ff <= 1'b0;
    end else if (full_ff && cnt_ff == hxd_pkg::CNT_RST) begin
      rx_ff        <= shift_ff;
      frame_tgl_ff <= ~frame_tgl_ff;
    end
  end

  // R20: warning bit out as soon as chip select falls
  always_comb begin
    serial_out_oe_o = ~csn;
    serial_out_o    = csn ? 1'b0 :
                      (tx_idx_ff == hxd_pkg::CNT_RST) ? status_word[hxd_pkg::BIT_TW] : stat_hold_ff[tx_idx_ff];
  end

  // ---------------- system domain ----------------
  logic        en_s;
  logic        tgl_s;
  logic        tgl_d_ff;
  logic        sel_n_s;
  hxd_pkg::hxd_sense_t sns;

  hxd_sync #(.W(2), .RST_VAL(1'b0)) u_ctl_sync (
    .clk_i (clk_i),
    .rst_i (sys_rst_i),
    .d_i   ({enable_i, frame_tgl_ff}),
    .q_o   ({en_s, tgl_s})
  );

  hxd_sync #(.W($bits(hxd_pkg::hxd_sense_t)), .RST_VAL(1'b0)) u_sns_sync (
    .clk_i (clk_i),
    .rst_i (sys_rst_i),
    .d_i   (sense_i),
    .q_o   (sns)
  );

  // chip select seen here; it is a gated pin pair, taken as a level only
  hxd_sync #(.W(1), .RST_VAL(1'b1)) u_sel_sync (
    .clk_i (clk_i),
    .rst_i (sys_rst_i),
    .d_i   (csn),
    .q_o   (sel_n_s)
  );

  // status held still while a frame runs; the link reads it unsynced,
  // relying on the chip select setup time before the first sclk fall
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_hold_ff <= hxd_pkg::FRAME_RST;
    end else if (sel_n_s) begin
      stat_hold_ff <= status_word;
    end
  end

  logic frame_evt;
  assign frame_evt = tgl_s ^ tgl_d_ff;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tgl_d_ff <= 1'b0;
    end else begin
      tgl_d_ff <= tgl_s;
    end
  end

  // rx_ff is stable for many clocks after the toggle crosses
  hxd_pkg::hxd_cmd_t cmd;
  // R02: frame fields to command
  assign cmd = hxd_pkg::hxd_cmd_t'(rx_ff);

  logic active;
  // R07: no frame applied until logic supply out of lockout
  assign active = en_s & sns.vcc_ok;

  logic apply;
  assign apply = frame_evt & active;

  logic status_reset_command;
  // R19: status reset command bit
  assign status_reset_command = apply & cmd.status_reset_command;

  // programmed state
  logic [11:0] sel_ff;
  logic        ocd_en_ff;
  logic        uld_en_ff;
  logic        overvoltage_shutdown_enable_en_ff;

  // R04: sleep wipes programming; R06 outputs start off
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_ff     <= 12'h000;
      ocd_en_ff  <= 1'b0;
      uld_en_ff  <= 1'b0;
      overvoltage_shutdown_enable_en_ff <= 1'b0;
    end else if (!active) begin
      sel_ff     <= 12'h000;
      ocd_en_ff  <= 1'b0;
      uld_en_ff  <= 1'b0;
      overvoltage_shutdown_enable_en_ff <= 1'b0;
    end else if (apply) begin
      sel_ff     <= cmd.outs;
      ocd_en_ff  <= cmd.ocd_en;
      uld_en_ff  <= cmd.uld_en;
      overvoltage_shutdown_enable_en_ff <= cmd.overvoltage_shutdown_enable_en;
    end
  end

  // underload timers, one per output
  logic [UW-1:0] ul_cnt_ff [hxd_pkg::OUT_COUNT];
  logic [11:0]   ul_hit;

  // R13: underload must persist beyond delay
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < hxd_pkg::OUT_COUNT; i++) begin
        ul_cnt_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < hxd_pkg::OUT_COUNT; i++) begin
        if (!(sns.ul[i] && half_bridge_output_o[i])) begin
          ul_cnt_ff[i] <= '0;
        end else if (ul_cnt_ff[i] != UW'(ULD_CYC)) begin
          ul_cnt_ff[i] <= ul_cnt_ff[i] + UW'(1);
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < hxd_pkg::OUT_COUNT; i++) begin
      ul_hit[i] = (ul_cnt_ff[i] == UW'(ULD_CYC));
    end
  end

  // latch-off masks and sticky flags
  logic [11:0] latch_off_ff;
  logic        old_ff;
  logic        uld_st_ff;
  logic        psf_ff;
  logic        tw_ff;

  // R10 R14: per output latch off; R22 set wins over release
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_off_ff <= 12'h000;
    end else if (!active) begin
      latch_off_ff <= 12'h000;
    end else begin
      latch_off_ff <= (status_reset_command ? 12'h000 : latch_off_ff)
                    | ({12{ocd_en_ff}} & sns.oc)
                    | ({12{uld_en_ff}} & ul_hit);
    end
  end

  // set beats clear when both land in one cycle
  function automatic logic set_wins(input logic cur, input logic clr, input logic hit);
    return (cur & ~clr) | hit;
  endfunction

  // R11 R13 R15 R17 sticky flags, set beats clear; R19 clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      old_ff    <= 1'b0;
      uld_st_ff <= 1'b0;
      psf_ff    <= 1'b0;
      tw_ff     <= 1'b0;
    end else if (!active) begin
      old_ff    <= 1'b0;
      uld_st_ff <= 1'b0;
      psf_ff    <= 1'b0;
      tw_ff     <= 1'b0;
    end else begin
      old_ff    <= set_wins(old_ff, status_reset_command, |sns.oc);
      uld_st_ff <= set_wins(uld_st_ff, status_reset_command, |ul_hit);
      psf_ff    <= set_wins(psf_ff, status_reset_command, sns.ov | sns.uv_drv);
      tw_ff     <= set_wins(tw_ff, status_reset_command, |sns.tw);
    end
  end

  // output gating
  logic any_ot;
  assign any_ot = |sns.ot;

  // R12 R18 over temperature blanks all; R15 R16 overvoltage blanks when its shutdown is enabled, selection kept
  // R08 driver undervoltage; R09 overcurrent alone never blanks
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      half_bridge_output_o <= 12'h000;
    end else if (!active || any_ot || sns.uv_drv || (overvoltage_shutdown_enable_en_ff && sns.ov)) begin
      half_bridge_output_o <= 12'h000;
    end else begin
      half_bridge_output_o <= sel_ff & ~latch_off_ff;
    end
  end

  // R03 status word layout
  always_comb begin
    status_word                         = 16'h0000;
    status_word[hxd_pkg::BIT_PSF]       = psf_ff;
    status_word[hxd_pkg::BIT_ULD_ST]    = uld_st_ff;
    status_word[hxd_pkg::BIT_OLD_ST]    = old_ff;
    status_word[12:1]                   = half_bridge_output_o;
    status_word[hxd_pkg::BIT_TW]        = tw_ff;
  end
endmodule // hxd_core

//--- dv/hxd_core_sva.sv
// Purpose: port checks for hxd_core
// Assumes: sense levels pass a two-flop sync
// Notes:   bound to every hxd_core
`timescale 1ns/10ps
module hxd_core_chk #(
  parameter int ULD_CYC = 8
) (
  // watched ports
  input wire logic                clk_i,
  input wire logic                sys_rst_i,
  input wire logic                enable_i,
  input wire logic                chip_select_n_i,
  input wire logic                chip_select_n_oe_i,
  input wire logic                serial_out_o,
  input wire logic                serial_out_oe_o,
  input wire hxd_pkg::hxd_sense_t sense_i,
  input wire logic [11:0]         half_bridge_output_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_SO_LOW: assert property (!serial_out_oe_o |-> !serial_out_o)
    else $error("serial out not low when off");
  AST_OE_DESEL: assert property ((chip_select_n_i || !chip_select_n_oe_i) |-> !serial_out_oe_o)
    else $error("serial out driven while deselected");
  AST_OE_SEL: assert property (enable_i[*4] ##0 (!chip_select_n_i && chip_select_n_oe_i) |-> serial_out_oe_o)
    else $error("serial out not driven while selected");
  AST_RST_OFF: assert property ($past(sys_rst_i) |-> half_bridge_output_o == 12'h000)
    else $error("outputs on after reset");
  AST_SLEEP: assert property ((!enable_i)[*4] |-> half_bridge_output_o == 12'h000)
    else $error("outputs on in sleep");
  AST_OT: assert property ((|sense_i.ot)[*5] |-> half_bridge_output_o == 12'h000)
    else $error("outputs on while over temperature");
  AST_UV: assert property (sense_i.uv_drv[*5] |-> half_bridge_output_o == 12'h000)
    else $error("outputs on in undervoltage");
  AST_HOLD: assert property ((!chip_select_n_i && chip_select_n_oe_i && enable_i && $stable(sense_i)
    && sense_i.ul == 12'h000)[*8] |-> $stable(half_bridge_output_o))
    else $error("outputs changed inside a frame");
  AST_TW: assert property (((|sense_i.tw) && enable_i)[*8] ##1 ($fell(chip_select_n_i) && chip_select_n_oe_i)
    |-> serial_out_o)
    else $error("warning not shown at select");
  COV_FRAME: cover property ($rose(chip_select_n_i) ##[1:8] $changed(half_bridge_output_o));
  COV_POLL: cover property ($fell(chip_select_n_i) && serial_out_o);
  COV_OT: cover property ((|sense_i.ot) && $fell(|half_bridge_output_o));
endmodule // hxd_core_chk

bind hxd_core hxd_core_chk #(.ULD_CYC(ULD_CYC)) i_hxd_core_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .enable_i(enable_i), .chip_select_n_i(chip_select_n_i), .chip_select_n_oe_i(chip_select_n_oe_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .sense_i(sense_i),
  .half_bridge_output_o(half_bridge_output_o));

//--- dv/hxd_host.sv
// Purpose: host side of the serial link
// Assumes: link clock 6 ns, stands still between frames
// Notes:   floating select drives low to catch a missing enable check
`timescale 1ns/10ps
module hxd_host (
  // serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      cs_n_oe_o,
  output logic      si_o,
  input  wire logic so_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    cs_n_oe_o = 1'b1;
    si_o = 1'b0;
  end
  // lsb first, setup and high time kept
  task automatic frame(input logic [15:0] w, input int n, input logic flt, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n_oe_o = !flt;
    cs_n_o = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      si_o = w[i];
      #1 rx[i] = so_i;
      #2 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
    end
    #3 cs_n_o = 1'b1;
    cs_n_oe_o = 1'b1;
    si_o = !si_o;
    #250;
  endtask
  task automatic poll(output logic tw);
    cs_n_o = 1'b0;
    #50 tw = so_i;
    #50 cs_n_o = 1'b1;
    #250;
  endtask
endmodule // hxd_host

//--- dv/test_hxd_core.sv
// Purpose: frame level tests of hxd_core
// Assumes: underload delay shortened to 8 cycles
// Notes:   status read back on the second of two frames
`timescale 1ns/10ps
module test_hxd_core;
  logic clk_i, sys_rst_i, enable_i, sclk, cs_n, cs_n_oe, si, so, so_oe, tw;
  hxd_pkg::hxd_sense_t sense;
  logic [11:0] outs;
  logic [15:0] rx;
  int errors, checked, cyc;
  hxd_core #(.ULD_CYC(8)) i_hxd_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i), .sclk_i(sclk),
    .chip_select_n_i(cs_n), .chip_select_n_oe_i(cs_n_oe), .serial_in_i(si), .serial_out_o(so),
    .serial_out_oe_o(so_oe), .sense_i(sense), .half_bridge_output_o(outs));
  hxd_host i_hxd_host (.sclk_o(sclk), .cs_n_o(cs_n), .cs_n_oe_o(cs_n_oe), .si_o(si), .so_i(so));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic co(input logic [11:0] e);
    // look at the outputs away from the edge that updates them
    @(negedge clk_i);
    chk({4'h0, outs}, {4'h0, e});
    @(posedge clk_i);
  endtask
  task automatic fr(input logic [15:0] w);
    i_hxd_host.frame(w, 16, 1'b0, rx);
    wt(8);
  endtask
  task automatic rd(input logic [15:0] w);
    fr(w);
    fr(w);
  endtask
  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    enable_i = 1'b1;
    sense = '0;
    sense.vcc_ok = 1'b1;
    errors = 0;
    checked = 0;
    cyc = 0;
    wt(2);
    sys_rst_i <= 1'b0;
    wt(6);
    co(12'h000);
    fr(16'h14B8);
    co(12'hA5C);
    rd(16'h14B8);
    chk(rx, 16'h14B8);
    i_hxd_host.frame(16'h0002, 15, 1'b0, rx);
    wt(8);
    co(12'hA5C);
    i_hxd_host.frame(16'h0002, 16, 1'b1, rx);
    wt(8);
    co(12'hA5C);
    sense.oc[2] <= 1'b1;
    wt(10);
    co(12'hA5C);
    sense.oc[2] <= 1'b0;
    rd(16'h14B8);
    chk(rx, 16'h34B8);
    rd(16'h14B9);
    chk(rx, 16'h14B8);
    fr(16'h34B8);
    sense.oc[2] <= 1'b1;
    wt(10);
    sense.oc[2] <= 1'b0;
    fr(16'h34B8);
    co(12'hA58);
    fr(16'h34B9);
    co(12'hA5C);
    fr(16'h54B8);
    sense.ul[3] <= 1'b1;
    wt(20);
    co(12'hA54);
    sense.ul[3] <= 1'b0;
    rd(16'h54B8);
    chk(rx, 16'h54A8);
    fr(16'h54B9);
    co(12'hA5C);
    fr(16'h94B8);
    sense.ov <= 1'b1;
    wt(10);
    co(12'h000);
    sense.ov <= 1'b0;
    wt(10);
    co(12'hA5C);
    rd(16'h94B8);
    chk(rx, 16'h94B8);
    sense.ot[1] <= 1'b1;
    wt(10);
    co(12'h000);
    fr(16'h1FFE);
    co(12'h000);
    sense.ot[1] <= 1'b0;
    wt(10);
    co(12'hFFF);
    sense.uv_drv <= 1'b1;
    wt(10);
    co(12'h000);
    sense.uv_drv <= 1'b0;
    sense.tw[0] <= 1'b1;
    wt(10);
    co(12'hFFF);
    i_hxd_host.poll(tw);
    chk({15'h0000, tw}, 16'h0001);
    co(12'hFFF);
    sense.tw[0] <= 1'b0;
    wt(10);
    i_hxd_host.poll(tw);
    chk({15'h0000, tw}, 16'h0001);
    fr(16'h1FFF);
    wt(10);
    i_hxd_host.poll(tw);
    chk({15'h0000, tw}, 16'h0000);
    enable_i <= 1'b0;
    wt(6);
    co(12'h000);
    enable_i <= 1'b1;
    wt(6);
    co(12'h000);
    results();
  end
endmodule // test_hxd_core
